// ==== design/epi_pkg.sv ====
// Constants and types shared by the external pin interrupt latch
package epi_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [15:0] ADDR_STATUS_CTRL = 16'h001D;
   localparam logic [15:0] ADDR_OPTION_TWO = 16'h001E;

   // ------------------------------------------------------------
   // Status and control fields
   // ------------------------------------------------------------
   localparam int SCR_MODE_BIT = 0;
   localparam int SCR_MASK_BIT = 1;
   localparam int SCR_ACK_BIT = 2;
   localparam int SCR_PEND_BIT = 3;

   // ------------------------------------------------------------
   // Option register two fields and reset
   // ------------------------------------------------------------
   localparam int OPT2_PUD_BIT = 0;
   localparam int OPT2_PIN_EN_BIT = 1;
   localparam logic [7:0] OPT2_RESET = 8'h00;

   // ------------------------------------------------------------
   // Vector location of this request
   // ------------------------------------------------------------
   localparam logic [15:0] VECTOR_ADDR_HI = 16'hFFFA;
   localparam logic [15:0] VECTOR_ADDR_LO = 16'hFFFB;

   // ------------------------------------------------------------
   // State types
   // ------------------------------------------------------------
   typedef struct packed {
      logic latch;
      logic ack_seen;
      logic mode;
      logic mask;
      logic lvl_prev;
      logic [7:0] opt2;
      logic [7:0] rdata;
   } epi_state_t;

   localparam epi_state_t EPI_STATE_RESET = '{latch: 1'b0,
      ack_seen: 1'b0, mode: 1'b0, mask: 1'b0, lvl_prev: 1'b1,
      opt2: OPT2_RESET, rdata: 8'h00};

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } epi_sync_t;

   localparam epi_sync_t EPI_SYNC_RESET = '{s1: 1'b1, s2: 1'b1,
      s3: 1'b1, lvl: 1'b1};

endpackage

// ==== design/epi_sync_if.sv ====
// Carrier of the synchronised pin level between the design modules
interface epi_sync_if;
   logic pin_level;
   modport src (output pin_level);
   modport dst (input pin_level);
endinterface

// ==== design/epi_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
module epi_pin_sync import epi_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic pin_raw,
   epi_sync_if.src sif
);

   epi_sync_t sy_q;
   epi_sync_t sy_d;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      sy_d = sy_q;
      sy_d.s1 = pin_raw;
      sy_d.s2 = sy_q.s1;
      sy_d.s3 = sy_q.s2;
      if (sy_q.s2 == sy_q.s3) begin
         sy_d.lvl = sy_q.s3;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sy_q <= EPI_SYNC_RESET;
      end else begin
         sy_q <= sy_d;
      end
   end

   assign sif.pin_level = sy_q.lvl;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sync_agree_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      $changed(sy_q.lvl) |-> $past(sy_q.s2) == $past(sy_q.s3))
      else $error("pin level moved without agreement");

endmodule

// ==== design/epi_ext_irq_latch.sv ====
// External pin interrupt latch with status, mask and option registers
//
// Contract
// - Pin interrupt function active only while pin enable option bit is one.
// - Low on enabled pin sets latch per selected sensitivity.
// - Vector fetch acknowledge clears the latch that caused it.
// - Software writing one to acknowledge bit clears latch.
// - Reset clears latch and sensitivity bit even with pin low.
// - Sensitivity bit picks edge-only or edge-plus-level triggering.
// - Edge mode: request holds until acknowledge or reset, then clears.
// - Level mode: clear needs acknowledge and pin high, any order.
// - Falling edge after acknowledge write latches a new request.
// - Mask bit set withholds the request from the CPU.
// - CPU global interrupt mask also blocks the request.
// - Serviced request vectors through the two fixed vector locations.
// - Pending flag reads independent of the mask bit.
// - Pin branch tests see one when the pin function is off.
// - Pullup on by default, removed by pullup-disable option bit.
// - Sensitivity bit: one level, zero edge; read/write; reset clear.
// - Acknowledge bit write-only, reads zero, reset clear.
// - Mask bit read/write, one disables, reset clears it.
//
// Local design decision: the address-and-strobe port.
module epi_ext_irq_latch import epi_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic shared_port_c_pin,
   input wire logic vector_fetch,
   input wire logic cond_code_reg_ext_request_mask,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq_request,
   output logic ext_pending_flag,
   output logic [15:0] irq_vector_hi_addr,
   output logic [15:0] irq_vector_lo_addr,
   output logic ext_pin_function_enable,
   output logic pullup_enable,
   output logic branch_pin_level
);

   epi_state_t st_q;
   epi_state_t st_d;
   logic pin_en;
   logic pin_high;
   logic low_level;
   logic fall_edge;
   logic wr_scr;
   logic wr_opt2;
   logic soft_ack;
   logic any_ack;
   logic release_ok;
   logic pending;
   logic [7:0] scr_val;

   epi_sync_if sif ();

   // ------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------
   epi_pin_sync u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin_raw(shared_port_c_pin),
      .sif(sif.src)
   );

   // ------------------------------------------------------------
   // Decode and event terms
   // ------------------------------------------------------------
   assign pin_en = st_q.opt2[OPT2_PIN_EN_BIT];
   assign pin_high = sif.pin_level;
   assign low_level = pin_en & ~pin_high;
   assign fall_edge = pin_en & st_q.lvl_prev & ~pin_high;
   assign wr_scr = reg_wr & (reg_addr == ADDR_STATUS_CTRL);
   assign wr_opt2 = reg_wr & (reg_addr == ADDR_OPTION_TWO);
   assign soft_ack = wr_scr & reg_wdata[SCR_ACK_BIT];
   assign any_ack = soft_ack | vector_fetch;
   assign release_ok = (any_ack | st_q.ack_seen) & ~low_level;
   assign pending = st_q.latch | (st_q.mode & low_level);

   always_comb begin
      scr_val = 8'h00;
      scr_val[SCR_MODE_BIT] = st_q.mode;
      scr_val[SCR_MASK_BIT] = st_q.mask;
      scr_val[SCR_ACK_BIT] = 1'b0;
      scr_val[SCR_PEND_BIT] = pending;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.lvl_prev = pin_high;
      if (st_q.mode) begin
         // Low level keeps setting; clear needs ack and pin high
         st_d.latch = fall_edge | low_level |
            (st_q.latch & ~release_ok);
         st_d.ack_seen = st_d.latch & ~fall_edge &
            (any_ack | st_q.ack_seen);
      end else begin
         // Set wins over a same-cycle acknowledge
         st_d.latch = fall_edge | (st_q.latch & ~any_ack);
         st_d.ack_seen = 1'b0;
      end
      if (wr_scr) begin
         st_d.mode = reg_wdata[SCR_MODE_BIT];
         st_d.mask = reg_wdata[SCR_MASK_BIT];
      end
      if (wr_opt2) begin
         st_d.opt2 = reg_wdata;
      end
      st_d.rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr == ADDR_STATUS_CTRL) begin
            st_d.rdata = scr_val;
         end else if (reg_addr == ADDR_OPTION_TWO) begin
            st_d.rdata = st_q.opt2;
         end else begin
            st_d.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_q <= EPI_STATE_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata = st_q.rdata;
   assign ext_pending_flag = pending;
   assign irq_request = pending & ~st_q.mask & ~cond_code_reg_ext_request_mask;
   assign irq_vector_hi_addr = VECTOR_ADDR_HI;
   assign irq_vector_lo_addr = VECTOR_ADDR_LO;
   assign ext_pin_function_enable = pin_en;
   assign pullup_enable = ~st_q.opt2[OPT2_PUD_BIT];
   assign branch_pin_level = pin_en ? pin_high : 1'b1;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   latch_set_a: assert property (
      fall_edge |=> st_q.latch)
      else $error("falling edge did not set latch");

   edge_ack_a: assert property (
      !st_q.mode && st_q.latch && any_ack && !fall_edge && !wr_scr
      |=> !st_q.latch && !pending)
      else $error("edge mode acknowledge did not clear");

   level_hold_a: assert property (
      st_q.mode && low_level && !wr_scr |=> pending)
      else $error("level request dropped while pin low");

   level_release_a: assert property (
      st_q.mode && st_q.latch && any_ack && !wr_scr
      ##1 !low_level && !fall_edge && st_q.mode |=> !st_q.latch)
      else $error("level request kept after ack and high pin");

   mask_gate_a: assert property (
      st_q.mask || cond_code_reg_ext_request_mask |-> !irq_request)
      else $error("masked request reached CPU");

   unmask_pass_a: assert property (
      pending && !st_q.mask && !cond_code_reg_ext_request_mask |-> irq_request)
      else $error("unmasked request withheld");

   pend_read_a: assert property (
      reg_rd && reg_addr == ADDR_STATUS_CTRL |=>
      reg_rdata[SCR_PEND_BIT] == $past(pending) && !reg_rdata[SCR_ACK_BIT])
      else $error("status read wrong pending or ack bit");

   branch_one_a: assert property (
      !pin_en |-> branch_pin_level)
      else $error("branch level not one with pin off");

   pullup_off_a: assert property (
      wr_opt2 && reg_wdata[OPT2_PUD_BIT] |=> !pullup_enable)
      else $error("pullup not removed");

   reset_clear_a: assert property (
      disable iff (1'b0) reset |=> !st_q.latch && !st_q.mode && !st_q.mask)
      else $error("reset left latch or control bits set");

   pin_off_quiet_a: assert property (
      !pin_en |-> !fall_edge && !low_level)
      else $error("pin event seen with function off");

   pin_en_write_a: assert property (
      wr_opt2 |=>
      ext_pin_function_enable == $past(reg_wdata[OPT2_PIN_EN_BIT]))
      else $error("pin function enable not written");

   level_set_a: assert property (
      st_q.mode && low_level |=> st_q.latch)
      else $error("low level did not set latch");

   no_spurious_a: assert property (
      !st_q.latch && !low_level |=> !st_q.latch)
      else $error("latch set without pin event");

   vec_ack_clear_a: assert property (
      !st_q.mode && vector_fetch && !fall_edge |=> !st_q.latch)
      else $error("vector fetch did not clear latch");

   soft_ack_clear_a: assert property (
      !st_q.mode && wr_scr && reg_wdata[SCR_ACK_BIT] && !fall_edge
      |=> !st_q.latch)
      else $error("software acknowledge did not clear latch");

   reset_pend_a: assert property (
      disable iff (1'b0) reset |=>
      !ext_pending_flag && !irq_request && reg_rdata == 8'h00)
      else $error("request or read data left after reset");

   mode_write_a: assert property (
      wr_scr |=> st_q.mode == $past(reg_wdata[SCR_MODE_BIT]))
      else $error("sensitivity bit not written");

   edge_hold_a: assert property (
      !st_q.mode && st_q.latch && !vector_fetch &&
      !(wr_scr && reg_wdata[SCR_ACK_BIT]) |=> st_q.latch)
      else $error("edge request lost without acknowledge");

   level_keep_a: assert property (
      st_q.mode && st_q.latch && !st_q.ack_seen && !vector_fetch &&
      !(wr_scr && reg_wdata[SCR_ACK_BIT]) |=> st_q.latch)
      else $error("level request lost without acknowledge");

   level_low_ack_a: assert property (
      st_q.mode && low_level && any_ack && !fall_edge
      |=> st_q.latch && st_q.ack_seen)
      else $error("acknowledge with pin low not remembered");

   level_drop_a: assert property (
      st_q.mode && st_q.ack_seen && !low_level |=> !st_q.latch)
      else $error("level request kept after pin release");

   mask_write_a: assert property (
      wr_scr |=> st_q.mask == $past(reg_wdata[SCR_MASK_BIT]))
      else $error("mask bit not written");

   ctrl_hold_a: assert property (
      !wr_scr |=> $stable(st_q.mode) && $stable(st_q.mask))
      else $error("control bits moved without a write");

   mask_bit_gate_a: assert property (
      st_q.mask |-> !irq_request)
      else $error("request passed the mask bit");

   ext_request_mask_gate_a: assert property (
      cond_code_reg_ext_request_mask |-> !irq_request)
      else $error("request passed the global mask");

   pend_latch_a: assert property (
      st_q.latch |-> ext_pending_flag)
      else $error("pending flag low with latch set");

   level_pend_a: assert property (
      st_q.mode && low_level |-> ext_pending_flag)
      else $error("pending flag low with level request");

   pend_idle_a: assert property (
      !st_q.latch && !(st_q.mode && low_level) |-> !ext_pending_flag)
      else $error("pending flag high with no request");

   opt2_write_a: assert property (
      wr_opt2 |=> st_q.opt2 == $past(reg_wdata))
      else $error("option register not written");

   pullup_on_a: assert property (
      wr_opt2 && !reg_wdata[OPT2_PUD_BIT] |=> pullup_enable)
      else $error("pullup not restored");

   pullup_reset_a: assert property (
      disable iff (1'b0) reset |=>
      pullup_enable && !ext_pin_function_enable && branch_pin_level)
      else $error("pin options wrong after reset");

   mode_read_a: assert property (
      reg_rd && reg_addr == ADDR_STATUS_CTRL |=>
      reg_rdata[SCR_MODE_BIT] == $past(st_q.mode))
      else $error("status read wrong sensitivity bit");

   mask_read_a: assert property (
      reg_rd && reg_addr == ADDR_STATUS_CTRL |=>
      reg_rdata[SCR_MASK_BIT] == $past(st_q.mask))
      else $error("status read wrong mask bit");

   opt_read_a: assert property (
      reg_rd && reg_addr == ADDR_OPTION_TWO |=>
      reg_rdata == $past(st_q.opt2))
      else $error("option register read wrong");

   rdata_idle_a: assert property (
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero without a read");

   unmapped_rd_a: assert property (
      reg_rd && reg_addr != ADDR_STATUS_CTRL &&
      reg_addr != ADDR_OPTION_TWO |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   unmapped_wr_a: assert property (
      reg_wr && reg_addr != ADDR_STATUS_CTRL && reg_addr != ADDR_OPTION_TWO
      |=> $stable(st_q.mode) && $stable(st_q.mask) && $stable(st_q.opt2))
      else $error("unmapped write changed a register");

   edge_once_a: assert property (
      fall_edge |=> !fall_edge)
      else $error("one pin fall seen twice");

endmodule

// ==== dv/epi_pin_src.sv ====
// Signal source that drives the shared interrupt pin
module epi_pin_src (
   input wire logic ref_clk,
   input wire logic drive_low,
   input wire logic pullup_en,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pin = 1'b1;
   // Released pin follows the pullup, or floats as a toggling level
   always @(posedge ref_clk) begin
      if (drive_low) pin <= 1'b0;
      else if (pullup_en) pin <= 1'b1;
      else pin <= ~pin;
   end
endmodule

// ==== dv/epi_ext_irq_latch_tb.sv ====
// Self-checking bench of the external pin interrupt latch
module epi_ext_irq_latch_tb;
   import epi_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic drive_low = 1'b0;
   logic vector_fetch = 1'b0;
   logic cond_code_reg_ext_request_mask = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata, rv;
   logic irq_request, ext_pending_flag, ext_pin_function_enable;
   logic pullup_enable, branch_pin_level, pin;
   logic [15:0] irq_vector_hi_addr, irq_vector_lo_addr;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   always #4 ref_clk = ~ref_clk;
   epi_pin_src i_src (.ref_clk, .drive_low, .pullup_en(pullup_enable), .pin);
   epi_ext_irq_latch i_dut (.ref_clk, .reset, .shared_port_c_pin(pin),
      .vector_fetch, .cond_code_reg_ext_request_mask, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .irq_request, .ext_pending_flag,
      .irq_vector_hi_addr, .irq_vector_lo_addr, .ext_pin_function_enable,
      .pullup_enable, .branch_pin_level);
   task stop_test;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         stop_test();
      end
   end
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task rd(input logic [15:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task pin_low(input logic v);
      @(posedge ref_clk) drive_low <= v;
   endtask
   task settle(input logic p);
      for (int i = 0; i < 12 && ext_pending_flag !== p; i++) begin
         @(posedge ref_clk);
         #1;
      end
      chk("pending", {15'h0, p}, {15'h0, ext_pending_flag});
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset;
      rd(ADDR_STATUS_CTRL);
      chk("status", 16'h0000, {8'h00, rv});
      rd(ADDR_OPTION_TWO);
      chk("option", 16'h0000, {8'h00, rv});
      rd(16'h0040);
      chk("unmapped", 16'h0000, {8'h00, rv});
      wr(16'h0040, 8'hFF);
      rd(ADDR_STATUS_CTRL);
      chk("status", 16'h0000, {8'h00, rv});
      rd(ADDR_OPTION_TWO);
      chk("option", 16'h0000, {8'h00, rv});
      chk("pullup", 16'h0001, {15'h0, pullup_enable});
      chk("vec hi", 16'hFFFA, irq_vector_hi_addr);
      chk("vec lo", 16'hFFFB, irq_vector_lo_addr);
      $display("done reset values");
   endtask
   task t_off;
      pin_low(1'b1);
      repeat (10) @(posedge ref_clk);
      #1 chk("pending", 16'h0000, {15'h0, ext_pending_flag});
      chk("branch", 16'h0001, {15'h0, branch_pin_level});
      pin_low(1'b0);
      repeat (6) @(posedge ref_clk);
      wr(ADDR_OPTION_TWO, 8'h02);
      chk("pin en", 16'h0001, {15'h0, ext_pin_function_enable});
      $display("done pin off");
   endtask
   task t_edge;
      pin_low(1'b1);
      settle(1'b1);
      chk("irq", 16'h0001, {15'h0, irq_request});
      chk("branch", 16'h0000, {15'h0, branch_pin_level});
      wr(ADDR_STATUS_CTRL, 8'h02);
      chk("irq", 16'h0000, {15'h0, irq_request});
      rd(ADDR_STATUS_CTRL);
      chk("status", 16'h000A, {8'h00, rv});
      wr(ADDR_STATUS_CTRL, 8'h00);
      @(posedge ref_clk) cond_code_reg_ext_request_mask <= 1'b1;
      #1 chk("irq", 16'h0000, {15'h0, irq_request});
      @(posedge ref_clk) cond_code_reg_ext_request_mask <= 1'b0;
      @(posedge ref_clk) vector_fetch <= 1'b1;
      @(posedge ref_clk) vector_fetch <= 1'b0;
      #1 chk("pending", 16'h0000, {15'h0, ext_pending_flag});
      pin_low(1'b0);
      repeat (6) @(posedge ref_clk);
      pin_low(1'b1);
      settle(1'b1);
      wr(ADDR_STATUS_CTRL, 8'h04);
      chk("pending", 16'h0000, {15'h0, ext_pending_flag});
      pin_low(1'b0);
      repeat (6) @(posedge ref_clk);
      pin_low(1'b1);
      settle(1'b1);
      wr(ADDR_STATUS_CTRL, 8'h04);
      pin_low(1'b0);
      $display("done edge mode");
   endtask
   task t_level;
      repeat (6) @(posedge ref_clk);
      wr(ADDR_STATUS_CTRL, 8'h01);
      pin_low(1'b1);
      settle(1'b1);
      wr(ADDR_STATUS_CTRL, 8'h03);
      wr(ADDR_STATUS_CTRL, 8'h05);
      repeat (3) @(posedge ref_clk);
      #1 chk("pending", 16'h0001, {15'h0, ext_pending_flag});
      pin_low(1'b0);
      settle(1'b0);
      pin_low(1'b1);
      settle(1'b1);
      pin_low(1'b0);
      repeat (8) @(posedge ref_clk);
      #1 chk("pending", 16'h0001, {15'h0, ext_pending_flag});
      wr(ADDR_STATUS_CTRL, 8'h05);
      chk("pending", 16'h0000, {15'h0, ext_pending_flag});
      pin_low(1'b1);
      settle(1'b1);
      pin_low(1'b0);
      repeat (8) @(posedge ref_clk);
      #1 chk("pending", 16'h0001, {15'h0, ext_pending_flag});
      @(posedge ref_clk) vector_fetch <= 1'b1;
      @(posedge ref_clk) vector_fetch <= 1'b0;
      #1 chk("pending", 16'h0000, {15'h0, ext_pending_flag});
      $display("done level mode");
   endtask
   task t_midreset;
      pin_low(1'b1);
      settle(1'b1);
      @(posedge ref_clk) reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      #1 chk("pending", 16'h0000, {15'h0, ext_pending_flag});
      rd(ADDR_STATUS_CTRL);
      chk("status", 16'h0000, {8'h00, rv});
      wr(ADDR_OPTION_TWO, 8'h03);
      chk("pullup", 16'h0000, {15'h0, pullup_enable});
      rd(ADDR_OPTION_TWO);
      chk("option", 16'h0003, {8'h00, rv});
      $display("done mid reset");
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      t_off();
      t_edge();
      t_level();
      t_midreset();
      stop_test();
   end
endmodule
